// *** verilog/aio_pkg.sv ***
/*
  Shared constants and types for the analog I/O scaling and fallback block:
  object numbers of the register map, field positions, reset values and widths.
  Assumes the register address is {object[15:0], sub_index[7:0]}.
*/
package aio_pkg;

  // Channel counts and widths
  localparam int AIO_NUM_AI  = 5;
  localparam int AIO_NUM_AO  = 3;
  localparam int AIO_NUM_SUP = 2;
  localparam int AIO_NUM_DI  = 8;
  localparam int AIO_ADDR_W  = 24;
  localparam int AIO_DATA_W  = 32;
  localparam int AIO_VAL_W   = 16;

  // Register objects (upper 16 address bits)
  localparam logic [15:0] AIO_OBJ_AI_VOLT   = 16'h6C01;
  localparam logic [15:0] AIO_OBJ_AO_SET    = 16'h6C11;
  localparam logic [15:0] AIO_OBJ_AO_ERRCTL = 16'h6C43;
  localparam logic [15:0] AIO_OBJ_AO_SUBST  = 16'h6C44;
  localparam logic [15:0] AIO_OBJ_AO_MODE   = 16'h46A1;
  localparam logic [15:0] AIO_OBJ_SUPPLY    = 16'h4693;
  localparam logic [15:0] AIO_OBJ_WIRE_BASE = 16'h46C0;
  localparam logic [15:0] AIO_OBJ_TEMP_CFG  = 16'h4620;
  localparam logic [15:0] AIO_OBJ_TEMP_STAT = 16'h4600;
  localparam logic [15:0] AIO_OBJ_TRIG      = 16'h4690;
  localparam logic [15:0] AIO_OBJ_DIN_STAT  = 16'h6800;
  localparam logic [15:0] AIO_OBJ_IRQ_STAT  = 16'h5000;
  localparam logic [15:0] AIO_OBJ_IRQ_CLR   = 16'h5001;
  localparam logic [15:0] AIO_OBJ_IRQ_EN    = 16'h5002;

  // Sub-indices of the thermistor configuration and digital status objects
  localparam logic [7:0] AIO_SUB_TEMP_MODE = 8'h00;
  localparam logic [7:0] AIO_SUB_TEMP_V100 = 8'h01;
  localparam logic [7:0] AIO_SUB_TEMP_V0   = 8'h02;
  localparam logic [7:0] AIO_SUB_DIN_NAT   = 8'h01;
  localparam logic [7:0] AIO_SUB_DIN_CONV  = 8'h02;

  // Field positions
  localparam int AIO_TEMP_SRC_LSB  = 0;
  localparam int AIO_TEMP_USER_BIT = 2;
  localparam int AIO_TEMP_DSEL_LSB = 4;
  localparam int AIO_DSEL_W        = 3;
  localparam int AIO_SUBST_LSB     = 16;
  localparam int AIO_EV_W          = 6;
  localparam int AIO_EV_COMM       = 5;

  // Reset values
  localparam logic [15:0] AIO_RST_RNG_MIN  = 16'h0000;
  localparam logic [15:0] AIO_RST_RNG_MAX  = 16'hFFFF;
  localparam logic [15:0] AIO_RST_TRIG_HI  = 16'h0300;
  localparam logic [15:0] AIO_RST_TRIG_LO  = 16'h0200;
  localparam logic [15:0] AIO_RST_SUPPLY   = 16'h0500;
  localparam logic [15:0] AIO_RST_SETPOINT = 16'h0000;
  localparam logic [31:0] AIO_RST_SUBST    = 32'h0000_0000;

  // Interpolation
  localparam int          AIO_DIV_W      = 24;
  localparam logic [6:0]  AIO_TEMP_SPAN  = 7'h64;

  // Motor temperature source
  typedef enum logic [1:0] {
    AIO_SRC_NONE,
    AIO_SRC_SWITCH,
    AIO_SRC_PTC
  } aio_temp_src_t;

endpackage : aio_pkg

// *** verilog/aio_interp_if.sv ***
/*
  Carrier between the main block and the thermistor interpolator.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ns
interface aio_interp_if;
  logic               start;
  logic [15:0]        volt;
  logic [15:0]        v_low;
  logic [15:0]        v_high;
  logic               busy;
  logic               done;
  logic signed [15:0] temp;
  modport req  (output start, volt, v_low, v_high, input busy, done, temp);
  modport calc (input start, volt, v_low, v_high, output busy, done, temp);
endinterface : aio_interp_if

// *** verilog/aio_chan_check.sv ***
/*
  One analog input channel: wire-off range check and analog-to-digital hysteresis.
  Assumes sample strobes come from converter logic on the same clock.
*/
`timescale 1ns/1ns
module aio_chan_check (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Sample
  input  wire logic        sample,
  input  wire logic [15:0] volt,
  // Settings
  input  wire logic [15:0] trig_high,
  input  wire logic [15:0] trig_low,
  input  wire logic [15:0] rng_min,
  input  wire logic [15:0] rng_max,
  // Results
  output logic             state_q,
  output logic             wire_off_q
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= 1'b0;
    end else if (sample) begin
      if (volt > trig_high) begin
        state_q <= 1'b1;
      end else if (volt < trig_low) begin
        state_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wire_off_q <= 1'b0;
    end else if (sample) begin
      wire_off_q <= (volt < rng_min) || (volt > rng_max);
    end
  end

endmodule : aio_chan_check

// *** verilog/aio_ptc_interp.sv ***
/*
  Linear interpolation of thermistor voltage to whole degrees Celsius.
  temp = (volt - v_low) * 100 / (v_high - v_low), by a serial restoring divider.
  Assumes start is only raised while busy is low.
*/
`timescale 1ns/1ns
module aio_ptc_interp
  import aio_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Request side
  aio_interp_if.calc  ifc
);

  typedef enum logic {AIO_IP_IDLE, AIO_IP_RUN} aio_ip_state_t;

  aio_ip_state_t          st_q;
  logic [AIO_DIV_W-1:0]   quo_q;
  logic [AIO_DIV_W:0]     rem_q;
  logic [16:0]            den_q;
  logic [4:0]             cnt_q;
  logic                   neg_q;
  logic signed [16:0]     diff;
  logic signed [16:0]     span;
  logic signed [AIO_DIV_W-1:0] num;
  logic [AIO_DIV_W:0]     rem_sh;
  logic                   fits;

  // Operand preparation and one divider step
  always_comb begin
    diff   = $signed({1'b0, ifc.volt}) - $signed({1'b0, ifc.v_low});
    span   = $signed({1'b0, ifc.v_high}) - $signed({1'b0, ifc.v_low});
    num    = AIO_DIV_W'(diff * $signed({1'b0, AIO_TEMP_SPAN}));
    rem_sh = {rem_q[AIO_DIV_W-1:0], quo_q[AIO_DIV_W-1]};
    fits   = rem_sh >= {{(AIO_DIV_W-16){1'b0}}, den_q};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q     <= AIO_IP_IDLE;
      quo_q    <= '0;
      rem_q    <= '0;
      den_q    <= '0;
      cnt_q    <= '0;
      neg_q    <= 1'b0;
      ifc.done <= 1'b0;
      ifc.temp <= '0;
    end else begin
      ifc.done <= 1'b0;
      case (st_q)
        AIO_IP_IDLE: begin
          if (ifc.start) begin
            if (span == 17'sd0) begin
              ifc.temp <= '0;  // Degenerate span reads as zero
              ifc.done <= 1'b1;
            end else begin
              neg_q <= (num < 0) ^ (span < 0);
              quo_q <= (num < 0) ? AIO_DIV_W'(-num) : AIO_DIV_W'(num);
              den_q <= (span < 0) ? 17'(-span) : 17'(span);
              rem_q <= '0;
              cnt_q <= 5'(AIO_DIV_W);
              st_q  <= AIO_IP_RUN;
            end
          end
        end
        AIO_IP_RUN: begin
          rem_q <= fits ? (rem_sh - {{(AIO_DIV_W-16){1'b0}}, den_q}) : rem_sh;
          quo_q <= {quo_q[AIO_DIV_W-2:0], fits};
          cnt_q <= cnt_q - 5'd1;
          if (cnt_q == 5'd1) begin
            ifc.temp <= neg_q ? -$signed({quo_q[14:0], fits}) : $signed({quo_q[14:0], fits});
            ifc.done <= 1'b1;
            st_q     <= AIO_IP_IDLE;
          end
        end
        default: st_q <= AIO_IP_IDLE;
      endcase
    end
  end

  assign ifc.busy = (st_q == AIO_IP_RUN);

endmodule : aio_ptc_interp

// *** verilog/aio_top.sv ***
/*
  Analog I/O scaling and fallback: analog input voltages, wire-off checks,
  analog-to-digital conversion, motor temperature, analog outputs with
  network-failure substitution, and one level interrupt.
  Assumes converter samples and the comm failure level arrive on clk;
  digital pins are asynchronous. Register address is {object, sub_index}.
*/
`timescale 1ns/1ns
// Operation
// - Input voltages are reported as 16-bit values, 1/256 V per bit.
// - Every analog input takes voltage or pot, and doubles as digital input.
// - Two sensor supply voltages are set by configuration registers.
// - Each input holds an allowed range; full range disables the check.
// - Motor temperature source is none, digital switch, or thermistor.
// - User thermistor temperature interpolates between 0 and 100 degree voltages.
// - Switch mode takes its state from a selectable digital input.
// - Measured temperature or switch state is readable as status.
// - Each channel has configurable high and low trigger voltages.
// - Digital status: native inputs at sub-index 1, converted at 2.
// - Three analog outputs drive contactor-type loads.
// - Each output selects voltage or current regulation.
// - Output setpoints are 16-bit, 1/256 V or A per bit.
// - On network failure each output holds or takes its substitute.
// - Substitute is a 32-bit word; only its upper 16 bits count.
module aio_top
  import aio_pkg::*;
#(
  parameter logic [15:0] BUILTIN_V0   = 16'h0400,  // Built-in sensor voltage at 0 degrees
  parameter logic [15:0] BUILTIN_V100 = 16'h0600   // Built-in sensor voltage at 100 degrees
) (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst,
  // Register port
  input  wire logic [aio_pkg::AIO_ADDR_W-1:0]      reg_addr,
  input  wire logic [aio_pkg::AIO_DATA_W-1:0]      reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [aio_pkg::AIO_DATA_W-1:0]      reg_rdata,
  // Converter samples
  input  wire logic                                adc_valid,
  input  wire logic [aio_pkg::AIO_NUM_AI-1:0][15:0] adc_volt,
  // Digital input pins
  input  wire logic [aio_pkg::AIO_NUM_DI-1:0]      din_pin,
  // Network state
  input  wire logic                                comm_fail,
  // Analog outputs
  output logic      [aio_pkg::AIO_NUM_AO-1:0][15:0] ao_value,
  output logic      [aio_pkg::AIO_NUM_AO-1:0]      ao_current_mode,
  // Sensor supplies
  output logic      [aio_pkg::AIO_NUM_SUP-1:0][15:0] supply_volt,
  // Input status
  output logic      [aio_pkg::AIO_NUM_AI-1:0]      wire_off,
  output logic      [aio_pkg::AIO_NUM_AI-1:0]      ai_digital,
  output logic signed [15:0]                       motor_temp,
  output logic                                     temp_switch,
  // Interrupt
  output logic                                     irq
);

  // Register storage
  logic [AIO_NUM_AI-1:0][15:0]  volt_q;
  logic [AIO_NUM_AI-1:0][15:0]  rng_min_q;
  logic [AIO_NUM_AI-1:0][15:0]  rng_max_q;
  logic [AIO_NUM_AI-1:0][15:0]  trig_hi_q;
  logic [AIO_NUM_AI-1:0][15:0]  trig_lo_q;
  logic [AIO_NUM_AO-1:0][15:0]  setpoint_q;
  logic [AIO_NUM_AO-1:0][31:0]  subst_q;
  logic [AIO_NUM_AO-1:0]        errctl_q;
  logic [1:0]                   temp_src_q;
  logic                         temp_user_q;
  logic [AIO_DSEL_W-1:0]        temp_dsel_q;
  logic [15:0]                  temp_v100_q;
  logic [15:0]                  temp_v0_q;
  logic [AIO_EV_W-1:0]          ev_stat_q;
  logic [AIO_EV_W-1:0]          ev_en_q;
  logic [AIO_NUM_DI-1:0]        din_meta_q;
  logic [AIO_NUM_DI-1:0]        din_q;
  logic [AIO_NUM_AI-1:0]        wire_off_prev_q;
  logic                         comm_prev_q;
  logic                         ptc_pend_q;

  // Decode helpers
  logic [15:0]                  obj;
  logic [7:0]                   sub;
  logic [AIO_EV_W-1:0]          ev_set;
  logic [AIO_EV_W-1:0]          ev_clr;
  logic [AIO_NUM_AI-1:0]        chan_state;
  logic [AIO_NUM_AI-1:0]        chan_fault;
  logic [AIO_DATA_W-1:0]        rdata_d;
  logic [15:0]                  ptc_lo;
  logic [15:0]                  ptc_hi;

  aio_interp_if                 ip_if ();

  assign obj = reg_addr[23:8];
  assign sub = reg_addr[7:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      volt_q <= '0;
    end else if (adc_valid) begin
      volt_q <= adc_volt;
    end
  end

  // Two-stage pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_meta_q <= '0;
      din_q      <= '0;
    end else begin
      din_meta_q <= din_pin;
      din_q      <= din_meta_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < AIO_NUM_AI; gi++) begin : g_chan
      aio_chan_check u_chk (
        .clk        (clk),
        .rst        (rst),
        .sample     (adc_valid),
        .volt       (adc_volt[gi]),
        .trig_high  (trig_hi_q[gi]),
        .trig_low   (trig_lo_q[gi]),
        .rng_min    (rng_min_q[gi]),
        .rng_max    (rng_max_q[gi]),
        .state_q    (chan_state[gi]),
        .wire_off_q (chan_fault[gi])
      );
    end
  endgenerate

  // Per-channel input settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < AIO_NUM_AI; i++) begin
        rng_min_q[i] <= AIO_RST_RNG_MIN;
        rng_max_q[i] <= AIO_RST_RNG_MAX;
        trig_hi_q[i] <= AIO_RST_TRIG_HI;
        trig_lo_q[i] <= AIO_RST_TRIG_LO;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < AIO_NUM_AI; i++) begin
        if (obj == AIO_OBJ_WIRE_BASE + 16'(i) && sub == 8'h00) begin
          rng_min_q[i] <= reg_wdata[15:0];
          rng_max_q[i] <= reg_wdata[31:16];
        end
        if (obj == AIO_OBJ_TRIG && sub == 8'(i + 1)) begin
          trig_lo_q[i] <= reg_wdata[15:0];
          trig_hi_q[i] <= reg_wdata[31:16];
        end
      end
    end
  end

  // Output and supply settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setpoint_q      <= '0;
      subst_q         <= '0;
      errctl_q        <= '0;
      ao_current_mode <= '0;
      supply_volt     <= '0;
      for (int i = 0; i < AIO_NUM_AO; i++) begin
        setpoint_q[i] <= AIO_RST_SETPOINT;
        subst_q[i]    <= AIO_RST_SUBST;
      end
      for (int i = 0; i < AIO_NUM_SUP; i++) begin
        supply_volt[i] <= AIO_RST_SUPPLY;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < AIO_NUM_AO; i++) begin
        if (obj == AIO_OBJ_AO_SET && sub == 8'(i + 1)) begin
          setpoint_q[i] <= reg_wdata[15:0];
        end
        if (obj == AIO_OBJ_AO_SUBST && sub == 8'(i + 1)) begin
          subst_q[i] <= reg_wdata;
        end
      end
      if (obj == AIO_OBJ_AO_MODE && sub == 8'h00) begin
        ao_current_mode <= reg_wdata[AIO_NUM_AO-1:0];
      end
      if (obj == AIO_OBJ_AO_ERRCTL && sub == 8'h00) begin
        errctl_q <= reg_wdata[AIO_NUM_AO-1:0];
      end
      for (int i = 0; i < AIO_NUM_SUP; i++) begin
        if (obj == AIO_OBJ_SUPPLY && sub == 8'(i + 1)) begin
          supply_volt[i] <= reg_wdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ao_value <= '0;
    end else begin
      for (int i = 0; i < AIO_NUM_AO; i++) begin
        if (comm_fail && errctl_q[i]) begin
          ao_value[i] <= subst_q[i][AIO_SUBST_LSB +: 16];
        end else begin
          ao_value[i] <= setpoint_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_src_q  <= 2'(AIO_SRC_NONE);
      temp_user_q <= 1'b0;
      temp_dsel_q <= '0;
      temp_v100_q <= BUILTIN_V100;
      temp_v0_q   <= BUILTIN_V0;
    end else if (reg_wr && obj == AIO_OBJ_TEMP_CFG) begin
      if (sub == AIO_SUB_TEMP_MODE) begin
        temp_src_q  <= reg_wdata[AIO_TEMP_SRC_LSB +: 2];
        temp_user_q <= reg_wdata[AIO_TEMP_USER_BIT];
        temp_dsel_q <= reg_wdata[AIO_TEMP_DSEL_LSB +: AIO_DSEL_W];
      end
      if (sub == AIO_SUB_TEMP_V100) begin
        temp_v100_q <= reg_wdata[15:0];
      end
      if (sub == AIO_SUB_TEMP_V0) begin
        temp_v0_q <= reg_wdata[15:0];
      end
    end
  end

  assign ptc_lo = temp_user_q ? temp_v0_q : BUILTIN_V0;
  assign ptc_hi = temp_user_q ? temp_v100_q : BUILTIN_V100;

  // Thermistor request: a sample arriving while busy waits for the divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptc_pend_q <= 1'b0;
    end else if (ip_if.start) begin
      ptc_pend_q <= 1'b0;
    end else if (adc_valid && temp_src_q == 2'(AIO_SRC_PTC)) begin
      ptc_pend_q <= 1'b1;
    end
  end

  assign ip_if.start  = ptc_pend_q && !ip_if.busy && !ip_if.done;
  assign ip_if.volt   = volt_q[AIO_NUM_AI-1];
  assign ip_if.v_low  = ptc_lo;
  assign ip_if.v_high = ptc_hi;

  aio_ptc_interp u_interp (
    .clk (clk),
    .rst (rst),
    .ifc (ip_if)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_temp  <= '0;
      temp_switch <= 1'b0;
    end else begin
      if (ip_if.done && temp_src_q == 2'(AIO_SRC_PTC)) begin
        motor_temp <= ip_if.temp;
      end
      temp_switch <= (temp_src_q == 2'(AIO_SRC_SWITCH)) ? din_q[temp_dsel_q] : 1'b0;
    end
  end

  // Channel status outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wire_off        <= '0;
      ai_digital      <= '0;
      wire_off_prev_q <= '0;
      comm_prev_q     <= 1'b0;
    end else begin
      wire_off        <= chan_fault;
      ai_digital      <= chan_state;
      wire_off_prev_q <= chan_fault;
      comm_prev_q     <= comm_fail;
    end
  end

  // Event sources and write-one clear
  assign ev_set = {comm_fail & ~comm_prev_q, chan_fault & ~wire_off_prev_q};
  assign ev_clr = (reg_wr && obj == AIO_OBJ_IRQ_CLR) ? reg_wdata[AIO_EV_W-1:0] : '0;

  // Sticky status, set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_stat_q <= '0;
    end else begin
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_en_q <= '0;
    end else if (reg_wr && obj == AIO_OBJ_IRQ_EN) begin
      ev_en_q <= reg_wdata[AIO_EV_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_stat_q & ev_en_q);
    end
  end

  // Read decode
  always_comb begin
    rdata_d = '0;
    case (obj)
      AIO_OBJ_AI_VOLT: begin
        for (int i = 0; i < AIO_NUM_AI; i++) begin
          if (sub == 8'(i + 1)) rdata_d = {16'h0000, volt_q[i]};
        end
      end
      AIO_OBJ_TRIG: begin
        for (int i = 0; i < AIO_NUM_AI; i++) begin
          if (sub == 8'(i + 1)) rdata_d = {trig_hi_q[i], trig_lo_q[i]};
        end
      end
      AIO_OBJ_AO_SET: begin
        for (int i = 0; i < AIO_NUM_AO; i++) begin
          if (sub == 8'(i + 1)) rdata_d = {16'h0000, setpoint_q[i]};
        end
      end
      AIO_OBJ_AO_SUBST: begin
        for (int i = 0; i < AIO_NUM_AO; i++) begin
          if (sub == 8'(i + 1)) rdata_d = subst_q[i];
        end
      end
      AIO_OBJ_SUPPLY: begin
        for (int i = 0; i < AIO_NUM_SUP; i++) begin
          if (sub == 8'(i + 1)) rdata_d = {16'h0000, supply_volt[i]};
        end
      end
      AIO_OBJ_AO_MODE: if (sub == 8'h00) rdata_d = 32'(ao_current_mode);
      AIO_OBJ_AO_ERRCTL: if (sub == 8'h00) rdata_d = 32'(errctl_q);
      AIO_OBJ_TEMP_CFG: begin
        if (sub == AIO_SUB_TEMP_MODE) begin
          rdata_d = 32'({temp_dsel_q, 1'b0, temp_user_q, temp_src_q});
        end
        if (sub == AIO_SUB_TEMP_V100) rdata_d = {16'h0000, temp_v100_q};
        if (sub == AIO_SUB_TEMP_V0) rdata_d = {16'h0000, temp_v0_q};
      end
      AIO_OBJ_TEMP_STAT: begin
        if (sub == 8'h00) begin
          if (temp_src_q == 2'(AIO_SRC_PTC)) rdata_d = 32'(unsigned'(motor_temp));
          else if (temp_src_q == 2'(AIO_SRC_SWITCH)) rdata_d = 32'(temp_switch);
        end
      end
      AIO_OBJ_DIN_STAT: begin
        if (sub == AIO_SUB_DIN_NAT) rdata_d = 32'(din_q);
        if (sub == AIO_SUB_DIN_CONV) rdata_d = 32'(ai_digital);
      end
      AIO_OBJ_IRQ_STAT: if (sub == 8'h00) rdata_d = 32'(ev_stat_q);
      AIO_OBJ_IRQ_EN: if (sub == 8'h00) rdata_d = 32'(ev_en_q);
      default: begin
        for (int i = 0; i < AIO_NUM_AI; i++) begin
          if (obj == AIO_OBJ_WIRE_BASE + 16'(i) && sub == 8'h00) begin
            rdata_d = {rng_max_q[i], rng_min_q[i]};
          end
        end
      end
    endcase
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : '0;
    end
  end

endmodule : aio_top

// *** testbench/aio_props.sv ***
/*
  Port checker for aio_top.
  Assumes one clock and strobes of one cycle.
*/
`timescale 1ns/1ns
module aio_props (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst,
  // Register port
  input wire logic [23:0]      reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  // Block state
  input wire logic             adc_valid,
  input wire logic             comm_fail,
  input wire logic [2:0][15:0] ao_value,
  input wire logic [2:0]       ao_current_mode,
  input wire logic [1:0][15:0] supply_volt,
  input wire logic [4:0]       wire_off,
  input wire logic [4:0]       ai_digital,
  input wire logic             irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 24'h70_0000 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_setpoint_to_out: assert property (reg_wr && reg_addr == 24'h6C_1101 && !comm_fail ##1 !comm_fail
    |=> ao_value[0] == $past(reg_wdata[15:0], 2)) else $error("setpoint not on output");
  a_out_hold_steady: assert property ($stable(comm_fail) && !reg_wr ##1 $stable(comm_fail) && !reg_wr
    |=> $stable(ao_value)) else $error("output moved without cause");
  a_cfg_hold_steady: assert property (!reg_wr ##1 !reg_wr
    |=> $stable(ao_current_mode) && $stable(supply_volt)) else $error("config moved without write");
  a_state_needs_sample: assert property (!adc_valid ##1 !adc_valid
    |=> $stable(ai_digital) && $stable(wire_off)) else $error("input state moved without sample");
  a_irq_mask_drop: assert property (reg_wr && reg_addr == 24'h50_0200 && reg_wdata[5:0] == 6'h0
    |-> ##2 !irq) else $error("irq stays with all masked");
  a_reset_values: assert property ($past(rst) |-> supply_volt == {16'h0500, 16'h0500} && ao_value == 48'h0)
    else $error("wrong value after reset");
  c_irq: cover property ($rose(irq));
  c_fail: cover property ($rose(comm_fail));
  c_wire: cover property ($rose(wire_off[0]));
endmodule : aio_props
bind aio_top aio_props i_aio_props (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid), .comm_fail(comm_fail),
  .ao_value(ao_value), .ao_current_mode(ao_current_mode), .supply_volt(supply_volt), .wire_off(wire_off),
  .ai_digital(ai_digital), .irq(irq));

// *** testbench/aio_adc_model.sv ***
/*
  Converter model feeding the analog inputs.
  Assumes one go pulse per sample on clk.
*/
`timescale 1ns/1ns
module aio_adc_model (
  // Clock
  input wire logic         clk,
  // Request
  input wire logic         go,
  input wire logic [15:0]  volt,
  // Converter side
  output logic             adc_valid,
  output logic [4:0][15:0] adc_volt
);
  // Quiet lines at time zero
  initial begin
    adc_valid = 1'b0;
    adc_volt = '0;
  end
  // one voltage on all channels
  // Lines show the inverse outside a sample
  always @(posedge clk) begin
    adc_valid <= go;
    adc_volt <= go ? {5{volt}} : ~{5{volt}};
  end
endmodule : aio_adc_model

// *** testbench/aio_top_tb_top.sv ***
/*
  Self-checking bench for aio_top.
  Assumes the converter model and the bound checker.
*/
`timescale 1ns/1ns
module aio_top_tb_top;
  import aio_pkg::*;
  typedef struct {logic [15:0] v; logic st; logic wo;} aio_row_t;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, comm_fail = 1'b0, go = 1'b0;
  logic [23:0] reg_addr = 24'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [15:0] volt = 16'h0;
  logic [7:0] din_pin = 8'h0;
  logic adc_valid, temp_switch, irq;
  logic [4:0][15:0] adc_volt;
  logic [2:0][15:0] ao_value;
  logic [2:0] ao_current_mode;
  logic [1:0][15:0] supply_volt;
  logic [4:0] wire_off, ai_digital;
  logic signed [15:0] motor_temp;
  int bad_count = 0, n_checks = 0, cyc = 0;
  aio_row_t rows [9] = '{'{16'h0400, 1, 0}, '{16'h0280, 1, 0}, '{16'h0300, 1, 0}, '{16'h01FF, 0, 0},
    '{16'h0200, 0, 0}, '{16'h0301, 1, 0}, '{16'h0050, 0, 1}, '{16'h0F01, 1, 1}, '{16'h0F00, 1, 0}};
  aio_top i_aio_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_volt(adc_volt), .din_pin(din_pin),
    .comm_fail(comm_fail), .ao_value(ao_value), .ao_current_mode(ao_current_mode), .supply_volt(supply_volt),
    .wire_off(wire_off), .ai_digital(ai_digital), .motor_temp(motor_temp), .temp_switch(temp_switch), .irq(irq));
  aio_adc_model i_aio_adc_model (.clk(clk), .go(go), .volt(volt), .adc_valid(adc_valid), .adc_volt(adc_volt));
  // Clock
  always #2 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [23:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic samp(input logic [15:0] v);
    @(posedge clk);
    go <= 1'b1;
    volt <= v;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : samp
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(24'h46_9301, 32'h0500);
    wr(24'h46_C000, 32'h0F00_0100);
    foreach (rows[i]) begin
      samp(rows[i].v);
      chk(ai_digital, {5{rows[i].st}});
      chk(wire_off, {4'h0, rows[i].wo});
      rd(24'h6C_0101, rows[i].v);
      rd(24'h68_0002, {5{rows[i].st}});
    end
    wr(24'h46_9002, 32'h0800_0700);
    samp(16'h0500);
    chk(ai_digital, 32'h1D);
    for (int k = 1; k <= 3; k++)
      wr(24'h6C_1100 + 24'(k), 32'h0100 * k);
    wr(24'h6C_4300, 32'h1);
    wr(24'h6C_4401, 32'h1234_ABCD);
    wr(24'h46_A100, 32'h2);
    wr(24'h46_9302, 32'h0A00);
    repeat (2) @(posedge clk);
    #1;
    for (int k = 0; k < 3; k++)
      chk(ao_value[k], 32'h0100 * (k + 1));
    chk(ao_current_mode, 32'h2);
    chk(supply_volt[1], 32'h0A00);
    rd(24'h6C_4401, 32'h1234_ABCD);
    @(posedge clk) comm_fail <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(ao_value[0], 32'h1234);
    chk(ao_value[1], 32'h0200);
    chk(irq, 32'h0);
    rd(24'h50_0000, 32'h21);
    wr(24'h50_0200, 32'h20);
    repeat (2) @(posedge clk);
    #1 chk(irq, 32'h1);
    wr(24'h50_0100, 32'h20);
    repeat (2) @(posedge clk);
    #1 chk(irq, 32'h0);
    rd(24'h50_0000, 32'h1);
    @(posedge clk) comm_fail <= 1'b0;
    @(posedge clk) comm_fail <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(irq, 32'h1);
    wr(24'h50_0200, 32'h0);
    @(posedge clk) comm_fail <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(irq, 32'h0);
    chk(ao_value[0], 32'h0100);
    wr(24'h46_2001, 32'h0800);
    wr(24'h46_2002, 32'h0400);
    wr(24'h46_2000, 32'h6);
    samp(16'h0600);
    repeat (40) @(posedge clk);
    #1 chk(motor_temp, 32'h32);
    rd(24'h46_0000, 32'h32);
    wr(24'h46_2000, 32'h2);
    samp(16'h0300);
    repeat (40) @(posedge clk);
    #1 chk(motor_temp, 32'hFFFF_FFCE);
    wr(24'h46_2000, 32'h31);
    @(posedge clk) din_pin <= 8'h08;
    repeat (5) @(posedge clk);
    #1 chk(temp_switch, 32'h1);
    rd(24'h46_0000, 32'h1);
    rd(24'h68_0001, 32'h08);
    rd(24'h70_0000, 32'h0);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(supply_volt[1], 32'h0500);
    chk(ao_value[0], 32'h0);
    @(posedge clk) rst <= 1'b0;
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule : aio_top_tb_top
